// >>> core/wds_params.svh
// constants of the watchdog and supply supervisor
`ifndef WDS_PARAMS_SVH
`define WDS_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define WDS_CFG_ADDR     8'h04
`define WDS_CFG_RESET    8'h11
`define WDS_CLR_BIT      7
`define WDS_SYS_LSB      5
`define WDS_MCU_LSB      2
`define WDS_LOCK_BIT     1
`define WDS_ON_BIT       0
`define WDS_SYS_NEVER    2'h0
`define WDS_SYS_EACH     2'h1
`define WDS_SYS_FOUR     2'h2
`define WDS_SYS_EIGHT    2'h3
`define WDS_SYS_CNT_MID  4
`define WDS_SYS_CNT_HI   8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDS_CLK_NS       50
`define WDS_TBASE_NS     10000000
`define WDS_TBASE_CYC    ((`WDS_TBASE_NS) / (`WDS_CLK_NS))
`define WDS_DEB_NS       20000
`define WDS_DEB_CYC      (((`WDS_DEB_NS) + (`WDS_CLK_NS) - 1) / (`WDS_CLK_NS))

// debounced levels at reset: pump reads out of range, supply in range
`define WDS_DEB_RESET    3'h4

`endif

// >>> core/wds_pkg.sv
// types shared by the watchdog and supply supervisor
package wds_pkg;

	typedef struct packed {
		logic pumpBad;
		logic undervolt;
		logic overvolt;
	} supply_in_t;

	typedef struct packed {
		logic supplyErr;
		logic pump;
		logic undervolt;
		logic overvolt;
	} supply_flags_t;

	typedef struct packed {
		logic supplyAutoclr;
		logic pumpAutoclr;
		logic overvoltProtect;
		logic undervoltProtect;
	} supply_ctrl_t;

endpackage

// >>> core/watchdog_supply_supervisor.sv
// watchdog timer and supply / charge-pump supervisor
`timescale 1ns/1ns
`include "wds_params.svh"

// What this block does
// - after power-on reset watchdog is on, 160ms MCU time-out, no system reset
// - clear bit 7 must be inverted by firmware often enough to avoid reset
// - clear-bit writes still act while the configuration is locked
// - system selector 00 never, 01 each, 10 after 4, 11 after 8 resets
// - MCU time-out is 10ms times two to the selector code
// - lock bit rejects further config writes, except to the clear bit, until power-on reset
// - enabled watchdog resets the MCU on time-out; disabled never resets
// - over- and under-voltage events set their flags
// - supply error flag is the OR of both voltage flags
// - voltage events shorter than 20us set no flag
// - a flag stays set while its condition persists, despite clears
// - with supply auto-clear, flags drop after 20us stable supply
// - over-voltage disables drivers unless its protection bit is clear
// - under-voltage disables drivers unless its protection bit is clear
// - charge-pump monitor runs always and is debounced by 20us
// - pump fault flag holds all drivers disabled
// - writing 1 clears pump fault only when pump is back in range
// - with pump auto-clear, fault drops after 20us valid pump
// - pump fault reads set after power-on reset and after wake from sleep
// - enabled watchdog counts a 10ms time base into two post-scalers
// - each clear-bit toggle restarts time base and both post-scalers
// - disabling the watchdog clears both post-scalers
// - while enabled, writes leave both time-out selectors unchanged
module watchdog_supply_supervisor #(
	parameter int TBASE_CYC = `WDS_TBASE_CYC,
	parameter int DEB_CYC   = `WDS_DEB_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            regAddr,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regWrData,
	output logic      [7:0]            regRdData,
	input  wire wds_pkg::supply_in_t   supplyIn,
	input  wire wds_pkg::supply_ctrl_t supplyCtrl,
	input  wire logic                  overvoltClr,
	input  wire logic                  undervoltClr,
	input  wire logic                  pumpClr,
	input  wire logic                  sleepWake,
	output wds_pkg::supply_flags_t     flags,
	output logic                       driversOff,
	output logic                       mcuResetReq,
	output logic                       sysResetReq
);

	localparam int TBW = $clog2(TBASE_CYC + 1);
	localparam int DBW = $clog2(DEB_CYC + 1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// last post-scaler count before the MCU time-out fires
	function automatic logic [7:0] postLimit(input logic [2:0] sel);
		postLimit = (8'h01 << sel) - 8'h01;
	endfunction

	// ----------------------------------------------------------------
	// configuration register
	// ----------------------------------------------------------------
	logic [7:0]     cfg_r;
	logic [7:0]     cfg_nxt;
	logic           cfgWrite;
	logic           clrEvent;
	logic           wdOn;
	logic           locked;
	logic [1:0]     sysSel;
	logic [2:0]     mcuSel;

	assign cfgWrite = regWrite && (regAddr == `WDS_CFG_ADDR);
	assign wdOn     = cfg_r[`WDS_ON_BIT];
	assign locked   = cfg_r[`WDS_LOCK_BIT];
	assign sysSel   = cfg_r[`WDS_SYS_LSB +: 2];
	assign mcuSel   = cfg_r[`WDS_MCU_LSB +: 3];
	// a rewrite of the same clear value is not a service
	assign clrEvent = cfgWrite && (regWrData[`WDS_CLR_BIT] != cfg_r[`WDS_CLR_BIT]);

	always_comb begin
		cfg_nxt = cfg_r;
		if (cfgWrite) begin
			cfg_nxt[`WDS_CLR_BIT] = regWrData[`WDS_CLR_BIT];
			if (!locked) begin
				cfg_nxt[`WDS_LOCK_BIT] = regWrData[`WDS_LOCK_BIT];
				cfg_nxt[`WDS_ON_BIT]   = regWrData[`WDS_ON_BIT];
				// selectors only move while the watchdog is stopped
				if (!wdOn) begin
					cfg_nxt[`WDS_SYS_LSB +: 2] = regWrData[`WDS_SYS_LSB +: 2];
					cfg_nxt[`WDS_MCU_LSB +: 3] = regWrData[`WDS_MCU_LSB +: 3];
				end
			end
		end
	end

	// only rst_n (power-on) restores the reset value and lifts the lock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= `WDS_CFG_RESET;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdData <= 8'h00;
		end else if (regRead) begin
			regRdData <= (regAddr == `WDS_CFG_ADDR) ? cfg_r : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// watchdog time base and post-scalers
	// ----------------------------------------------------------------
	logic [TBW-1:0] tbCnt_r;
	logic [7:0]     mcuPost_r;
	logic [3:0]     sysPost_r;
	logic           tick;
	logic           mcuTimeout;
	logic           sysTrip;

	assign tick       = wdOn && (tbCnt_r == TBW'(TBASE_CYC - 1));
	assign mcuTimeout = tick && (mcuPost_r == postLimit(mcuSel));

	always_comb begin
		case (sysSel)
			`WDS_SYS_NEVER: sysTrip = 1'b0;
			`WDS_SYS_EACH:  sysTrip = mcuTimeout;
			`WDS_SYS_FOUR:  sysTrip = mcuTimeout && (sysPost_r == 4'(`WDS_SYS_CNT_MID - 1));
			`WDS_SYS_EIGHT: sysTrip = mcuTimeout && (sysPost_r == 4'(`WDS_SYS_CNT_HI - 1));
			default:        sysTrip = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tbCnt_r <= '0;
		end else if (!wdOn || clrEvent || tick) begin
			tbCnt_r <= '0;
		end else begin
			tbCnt_r <= tbCnt_r + TBW'(1);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mcuPost_r <= 8'h00;
		end else if (!wdOn || clrEvent || mcuTimeout) begin
			mcuPost_r <= 8'h00;
		end else if (tick) begin
			mcuPost_r <= mcuPost_r + 8'h01;
		end
	end

	// counts consecutive MCU resets with no service in between
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sysPost_r <= 4'h0;
		end else if (!wdOn || clrEvent || sysTrip) begin
			sysPost_r <= 4'h0;
		end else if (mcuTimeout) begin
			sysPost_r <= sysPost_r + 4'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mcuResetReq <= 1'b0;
			sysResetReq <= 1'b0;
		end else begin
			mcuResetReq <= mcuTimeout;
			sysResetReq <= sysTrip;
		end
	end

	// ----------------------------------------------------------------
	// debounce of over-voltage, under-voltage and pump monitors
	// ----------------------------------------------------------------
	logic [2:0]     raw;
	logic [2:0]     deb_r;
	logic [DBW-1:0] debCnt_r [3];

	assign raw = supplyIn;

	// a level must differ for DEB_CYC cycles before it is believed
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			deb_r <= `WDS_DEB_RESET;
			for (int i = 0; i < 3; i++) begin
				debCnt_r[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (raw[i] == deb_r[i]) begin
					debCnt_r[i] <= '0;
				end else if (debCnt_r[i] == DBW'(DEB_CYC - 1)) begin
					deb_r[i]    <= raw[i];
					debCnt_r[i] <= '0;
				end else begin
					debCnt_r[i] <= debCnt_r[i] + DBW'(1);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// sticky flags and driver shutdown
	// ----------------------------------------------------------------
	logic ovFlag_r;
	logic uvFlag_r;
	logic pumpFlag_r;

	// set wins over any clear arriving in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ovFlag_r <= 1'b0;
		end else if (deb_r[0]) begin
			ovFlag_r <= 1'b1;
		end else if (overvoltClr || supplyCtrl.supplyAutoclr) begin
			ovFlag_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			uvFlag_r <= 1'b0;
		end else if (deb_r[1]) begin
			uvFlag_r <= 1'b1;
		end else if (undervoltClr || supplyCtrl.supplyAutoclr) begin
			uvFlag_r <= 1'b0;
		end
	end

	// pump has not settled after power-on or wake, so the flag starts set
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pumpFlag_r <= 1'b1;
		end else if (deb_r[2] || sleepWake) begin
			pumpFlag_r <= 1'b1;
		end else if (pumpClr || supplyCtrl.pumpAutoclr) begin
			pumpFlag_r <= 1'b0;
		end
	end

	assign flags.overvolt  = ovFlag_r;
	assign flags.undervolt = uvFlag_r;
	assign flags.pump      = pumpFlag_r;
	assign flags.supplyErr = ovFlag_r | uvFlag_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			driversOff <= 1'b1;
		end else begin
			driversOff <= pumpFlag_r
				| (ovFlag_r && supplyCtrl.overvoltProtect)
				| (uvFlag_r && supplyCtrl.undervoltProtect);
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence lockedWrite;
		cfgWrite && locked;
	endsequence

	sequence shortOvGlitch;
		!deb_r[0] && !raw[0] ##1 raw[0] ##1 !raw[0];
	endsequence

	lockStays_a: assert property (@(posedge mclk) disable iff (!rst_n)
		locked |=> locked)
		else $error("config lock dropped without power-on reset");

	lockedCfg_a: assert property (@(posedge mclk) disable iff (!rst_n)
		lockedWrite |=> cfg_r[6:0] == $past(cfg_r[6:0]))
		else $error("locked config changed on write");

	clrWrite_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgWrite |=> cfg_r[`WDS_CLR_BIT] == $past(regWrData[`WDS_CLR_BIT]))
		else $error("clear bit write not taken");

	selFrozen_a: assert property (@(posedge mclk) disable iff (!rst_n)
		cfgWrite && wdOn |=> cfg_r[6:2] == $past(cfg_r[6:2]))
		else $error("selector changed while watchdog enabled");

	offNoReset_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!wdOn |=> !mcuResetReq && !sysResetReq)
		else $error("reset issued while watchdog disabled");

	clrRestart_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clrEvent |=> tbCnt_r == '0 && mcuPost_r == 8'h00 && sysPost_r == 4'h0)
		else $error("toggle did not restart watchdog");

	offClears_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!wdOn |=> mcuPost_r == 8'h00 && sysPost_r == 4'h0)
		else $error("post-scalers kept while disabled");

	eachSys_a: assert property (@(posedge mclk) disable iff (!rst_n)
		mcuResetReq && $past(sysSel) == `WDS_SYS_EACH |-> sysResetReq)
		else $error("system reset missing in each-reset mode");

	supplyErr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		flags.supplyErr == (flags.overvolt || flags.undervolt))
		else $error("supply error flag differs from OR");

	glitchOv_a: assert property (@(posedge mclk) disable iff (!rst_n)
		shortOvGlitch |=> (!deb_r[0]) [*4])
		else $error("short over-voltage glitch was accepted");

	ovPersist_a: assert property (@(posedge mclk) disable iff (!rst_n)
		deb_r[0] ##1 deb_r[0] |-> ovFlag_r)
		else $error("over-voltage flag cleared during event");

	pumpDrv_a: assert property (@(posedge mclk) disable iff (!rst_n)
		pumpFlag_r |=> driversOff)
		else $error("drivers enabled during pump fault");

	wakePump_a: assert property (@(posedge mclk) disable iff (!rst_n)
		sleepWake |=> pumpFlag_r)
		else $error("pump fault flag not set on wake");

	pumpHold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		deb_r[2] |=> pumpFlag_r)
		else $error("pump fault cleared while pump out of range");

	ovDrivers_a: assert property (@(posedge mclk) disable iff (!rst_n)
		ovFlag_r && supplyCtrl.overvoltProtect |=> driversOff)
		else $error("drivers left on during protected over-voltage");

	uvDrivers_a: assert property (@(posedge mclk) disable iff (!rst_n)
		uvFlag_r && supplyCtrl.undervoltProtect |=> driversOff)
		else $error("drivers left on during protected under-voltage");

	autoClr_a: assert property (@(posedge mclk) disable iff (!rst_n)
		supplyCtrl.supplyAutoclr && !deb_r[0] |=> !ovFlag_r)
		else $error("over-voltage flag not auto-cleared");

endmodule // watchdog_supply_supervisor

// >>> sim/mcu_fw_model.sv
// firmware-side model: register port, clear requests, supply control levels
`timescale 1ns/1ns
module mcu_fw_model (
	input  wire logic             mclk,
	output logic [7:0]            regAddr,
	output logic                  regWrite,
	output logic                  regRead,
	output logic [7:0]            regWrData,
	output wds_pkg::supply_ctrl_t supplyCtrl,
	output logic                  overvoltClr,
	output logic                  undervoltClr,
	output logic                  pumpClr
);
	logic [7:0]  shadow = 8'h11;
	// {control levels, clear pulses, write, read, address, data}
	logic [24:0] cur    = {4'h3, 3'h0, 2'h0, 16'hffff};
	logic [24:0] cmdQ[$];
	logic        busy   = 1'b0;

	assign {supplyCtrl, pumpClr, undervoltClr, overvoltClr,
		regWrite, regRead, regAddr, regWrData} = cur;

	// ----------------------------------------------------------------
	// command player: drive at one falling edge, release at the next
	// ----------------------------------------------------------------
	// released bus never shows the stale address or data
	always @(negedge mclk) begin
		if (busy) begin
			cur  <= {cur[24:21], 5'h00, ~cur[15:0]};
			busy <= 1'b0;
		end else if (cmdQ.size() != 0) begin
			cur  <= cmdQ.pop_front();
			busy <= 1'b1;
		end
	end

	// queued at a rising edge so the player never races the caller
	task automatic issue(input logic [24:0] c);
		@(posedge mclk);
		cmdQ.push_back(c);
		repeat (2) @(negedge mclk);
	endtask

	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		issue({cur[24:21], 3'h0, wr, ~wr, a, d});
	endtask

	task automatic setCtrl(input logic [3:0] c);
		issue({c, 3'h0, 2'h0, cur[15:0]});
	endtask

	task automatic writeCfg(input logic [7:0] d);
		shadow[6:0] = d[6:0];
		access(1'b1, 8'h04, shadow);
	endtask

	task automatic service();
		shadow[7] = ~shadow[7];
		access(1'b1, 8'h04, shadow);
	endtask

	task automatic clearReq(input logic [2:0] m);
		issue({cur[24:21], m, 2'h0, cur[15:0]});
	endtask
endmodule // mcu_fw_model

// >>> sim/watchdog_supply_supervisor_tb_top.sv
// self-checking bench of the watchdog and supply supervisor
`timescale 1ns/1ns
module watchdog_supply_supervisor_tb_top;
	localparam int TB = 20;
	localparam int DB = 8;
	logic mclk, rst_n, regWrite, regRead, overvoltClr, undervoltClr, pumpClr;
	logic sleepWake, driversOff, mcuResetReq, sysResetReq, rdSeen;
	logic [7:0] regAddr, regWrData, regRdData, rdQ[$];
	logic [31:0] seed;
	logic sysQ[$];
	logic [4:0] e;
	wds_pkg::supply_in_t supplyIn;
	wds_pkg::supply_ctrl_t supplyCtrl;
	wds_pkg::supply_flags_t flags;
	int errCount = 0, totalChecks = 0, cyc = 0, lastPulse = 0, pulseGap = 0, pulseCnt = 0, c0;

	watchdog_supply_supervisor #(.TBASE_CYC(TB), .DEB_CYC(DB)) DUT (
		.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWrData(regWrData), .regRdData(regRdData),
		.supplyIn(supplyIn), .supplyCtrl(supplyCtrl), .overvoltClr(overvoltClr),
		.undervoltClr(undervoltClr), .pumpClr(pumpClr), .sleepWake(sleepWake),
		.flags(flags), .driversOff(driversOff), .mcuResetReq(mcuResetReq),
		.sysResetReq(sysResetReq)
	);
	mcu_fw_model fw (
		.mclk(mclk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
		.regWrData(regWrData), .supplyCtrl(supplyCtrl), .overvoltClr(overvoltClr),
		.undervoltClr(undervoltClr), .pumpClr(pumpClr)
	);

	always #25 mclk = ~mclk;

	// ----------------------------------------------------------------
	// checking helpers and result monitor
	// ----------------------------------------------------------------
	task automatic cmp(input logic [15:0] ex, input logic [15:0] got);
		totalChecks++;
		if (got !== ex) begin
			errCount++;
			$display("BAD t=%0t exp=%h got=%h", $time, ex, got);
		end
	endtask

	task automatic chkF(input logic [4:0] ex);
		cmp({11'h0, ex}, {11'h0, flags, driversOff});
	endtask

	task automatic endOfTest();
		if (errCount == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		rdQ.push_back(ex);
		fw.access(1'b0, a, 8'h00);
	endtask

	task automatic waitPulses(input int n, input int lim);
		int goal;
		goal = pulseCnt + n;
		for (int i = 0; i < lim && pulseCnt < goal; i++) @(posedge mclk);
		// back on the falling edge where stimulus changes
		@(negedge mclk);
		if (pulseCnt < goal) begin
			errCount++;
			$display("BAD t=%0t exp=%h got=%h", $time, goal, pulseCnt);
			endOfTest();
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	always @(posedge mclk) rdSeen <= regRead;

	// a reset pulse with nothing queued counts as unexpected
	always @(negedge mclk) begin
		cyc++;
		if (rdSeen === 1'b1) cmp({8'h0, rdQ.pop_front()}, {8'h0, regRdData});
		if (mcuResetReq === 1'b1) begin
			if (sysQ.size() == 0) cmp(16'h0, 16'h1);
			else cmp({15'h0, sysQ.pop_front()}, {15'h0, sysResetReq});
			pulseGap = cyc - lastPulse;
			lastPulse = cyc;
			pulseCnt++;
		end else if (sysResetReq !== 1'b0) cmp(16'h0, {15'h0, sysResetReq});
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		sleepWake = 1'b0;
		supplyIn = 3'h4;
		seed = 32'd97445;
		idle(3);
		rst_n = 1'b1;
		rd(8'h04, 8'h11);
		rd(8'h5a, 8'h00);
		chkF(5'h09);
		sysQ = '{1'b0, 1'b0};
		waitPulses(2, 800);
		cmp(16'(pulseGap), 16'(16 * TB));
		fw.writeCfg(8'h01);
		rd(8'h04, 8'h11);
		for (int m = 0; m < 8; m++) begin
			fw.writeCfg(8'h00);
			fw.writeCfg({3'h0, 3'(m), 2'h1});
			sysQ = '{1'b0, 1'b0};
			waitPulses(2, (TB << m) * 3);
			cmp(16'(pulseGap), 16'(TB << m));
		end
		for (int s = 1; s < 4; s++) begin
			fw.writeCfg(8'h00);
			fw.writeCfg({1'b0, 2'(s), 5'h01});
			for (int k = 1; k <= (1 << s); k++) sysQ.push_back(s == 1 || k == (1 << s));
			waitPulses(1 << s, (TB << s) * 2 + 40);
		end
		fw.writeCfg(8'h00);
		fw.writeCfg(8'h01);
		repeat (12) begin
			seed = xs(seed);
			idle(1 + int'(seed % 14));
			fw.service();
		end
		sysQ.push_back(1'b0);
		repeat (5) begin
			idle(4);
			fw.writeCfg(8'h01);
		end
		cmp(16'(sysQ.size()), 16'h0);
		fw.service();
		idle(12);
		fw.writeCfg(8'h00);
		fw.writeCfg(8'h01);
		c0 = cyc;
		sysQ.push_back(1'b0);
		waitPulses(1, 40);
		cmp(16'(lastPulse - c0 > 16), 16'h1);
		fw.writeCfg(8'h03);
		fw.writeCfg(8'h00);
		repeat (6) begin
			idle(10);
			fw.service();
		end
		rd(8'h04, {fw.shadow[7], 7'h03});
		sysQ.push_back(1'b0);
		waitPulses(1, 30);
		rst_n = 1'b0;
		idle(3);
		rst_n = 1'b1;
		fw.shadow = 8'h11;
		rd(8'h04, 8'h11);
		fw.writeCfg(8'h10);
		fw.clearReq(3'h4);
		idle(2);
		chkF(5'h09);
		supplyIn = 3'h0;
		idle(DB + 3);
		chkF(5'h09);
		fw.clearReq(3'h4);
		idle(3);
		chkF(5'h00);
		supplyIn = 3'h4;
		idle(DB + 3);
		chkF(5'h09);
		fw.setCtrl(4'h7);
		supplyIn = 3'h0;
		idle(DB + 4);
		chkF(5'h00);
		fw.setCtrl(4'h3);
		sleepWake = 1'b1;
		idle(1);
		sleepWake = 1'b0;
		idle(2);
		chkF(5'h09);
		fw.clearReq(3'h4);
		// one-cycle spike for the glitch property
		supplyIn[0] = 1'b1;
		idle(1);
		supplyIn[0] = 1'b0;
		idle(3);
		chkF(5'h00);
		for (int i = 0; i < 2; i++) begin
			e = {2'b10, 2'(1 << i), 1'b1};
			seed = xs(seed);
			supplyIn[i] = 1'b1;
			idle(1 + int'(seed % (DB - 2)));
			supplyIn[i] = 1'b0;
			idle(DB + 2);
			chkF(5'h00);
			supplyIn[i] = 1'b1;
			idle(DB + 3);
			chkF(e);
			fw.clearReq(3'(1 << i));
			idle(2);
			chkF(e);
			supplyIn[i] = 1'b0;
			idle(DB + 3);
			chkF(e);
			fw.clearReq(3'(1 << i));
			idle(3);
			chkF(5'h00);
			fw.setCtrl(4'h8 | 4'(1 << i));
			supplyIn[i] = 1'b1;
			idle(DB + 3);
			chkF(e & 5'h1e);
			supplyIn[i] = 1'b0;
			idle(DB + 4);
			chkF(5'h00);
			fw.setCtrl(4'h3);
		end
		endOfTest();
	end
endmodule // watchdog_supply_supervisor_tb_top
